// >>> imwc_delay_timer.sv
// Down-counter that delays a start pulse by a loaded number of cycles.
// Assumes load and start arrive on the system clock domain.
`timescale 1ns/1ps
module imwc_delay_timer import imwc_pkg::*; #(
  parameter int CntW = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Control
  input wire logic start,
  input wire logic [CntW-1:0] loadVal,
  // Status
  output logic busy,
  output logic done
);

  logic [CntW-1:0] countQ;
  logic busyQ;
  logic doneQ;

  initial begin
    if (CntW < 2) $error("imwc_delay_timer: CntW too small");
  end

  // Count down to one then pulse done; a start while busy restarts it
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      countQ <= '0;
      busyQ <= 1'b0;
      doneQ <= 1'b0;
    end else begin
      doneQ <= 1'b0;
      if (start) begin
        countQ <= loadVal;
        busyQ <= 1'b1;
      end else if (busyQ) begin
        if (countQ <= CntW'(1)) begin
          busyQ <= 1'b0;
          doneQ <= 1'b1;
        end else begin
          countQ <= countQ - CntW'(1);
        end
      end
    end
  end

  assign busy = busyQ;
  assign done = doneQ;

endmodule

// >>> imwc_fw_model.sv
// Model of the firmware and interrupt sources that face the controller.
// Assumes the bench calls its tasks between rising edges of clk_sys.
`timescale 1ns/1ps
module imwc_fw_model (
  // Clock
  input wire logic clk_sys,
  // Wake feedback
  input wire logic cpuResume,
  // Core events
  output logic sleepExec,
  output logic watchdogClearInstr,
  output logic irqFlag,
  output logic irqEnable,
  output logic irqIsPeripheral,
  output logic watchdogTimeout,
  output logic clockLoss
);
  initial begin
    {sleepExec, watchdogClearInstr, watchdogTimeout, clockLoss} = 4'h0;
    {irqFlag, irqEnable, irqIsPeripheral} = 3'h0;
  end

  // One-cycle strobe: 0 sleep, 1 clear-watchdog, 2 time-out, 3 clock loss
  task automatic strobe(input int which);
    @(posedge clk_sys);
    case (which)
      0: sleepExec <= 1'b1;
      1: watchdogClearInstr <= 1'b1;
      2: watchdogTimeout <= 1'b1;
      default: clockLoss <= 1'b1;
    endcase
  endtask

  // Each strobe lasts one cycle and is cleared on its own, so a fresh
  // strobe of another kind raised at the same edge is not eaten
  always @(posedge clk_sys) begin
    if (sleepExec) sleepExec <= 1'b0;
    if (watchdogClearInstr) watchdogClearInstr <= 1'b0;
    if (watchdogTimeout) watchdogTimeout <= 1'b0;
    if (clockLoss) clockLoss <= 1'b0;
  end

  // Raise an interrupt flag with its own enable and source kind
  task automatic irq(input logic en, input logic periph);
    @(posedge clk_sys);
    irqEnable <= en;
    irqIsPeripheral <= periph;
    irqFlag <= 1'b1;
  endtask

  // Firmware services the flag once the core runs again
  always @(posedge clk_sys) begin
    if (cpuResume) begin
      irqFlag <= 1'b0;
    end
  end
endmodule

// >>> imwc_idle_wake.sv
// Idle and wake controller: gates the CPU clock on sleep, selects the
// peripheral clock source, tracks clock status flags and times the wake.
// Assumes firmware drives the sleep and clear-watchdog strobes for one
// cycle, interrupt flags are synchronous, and software uses Wishbone.
`timescale 1ns/1ps
module imwc_idle_wake import imwc_pkg::*; #(
  parameter int CpuStartCyc = CPU_START_CYC,
  parameter int StabilizeCyc = STABILIZE_CYC,
  parameter int OstCyc = OST_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Core events
  input wire logic sleepExec,
  input wire logic watchdogClearInstr,
  input wire logic irqFlag,
  input wire logic irqEnable,
  input wire logic irqIsPeripheral,
  input wire logic watchdogTimeout,
  input wire logic clockLoss,
  // Clock control outputs
  output logic cpuClockEn,
  output logic periphClockEn,
  output logic [1:0] periphClockSrc,
  output logic primaryOscEn,
  output logic fastInternalOscEn,
  output logic slowInternalOscEn,
  // Core sequencing outputs
  output logic cpuResume,
  output logic branchToVector,
  output logic watchdogReset,
  output logic watchdogClear,
  output logic restartAtZero
);

  // Elaboration checks on timing counts
  initial begin
    if (CpuStartCyc < 1 || CpuStartCyc > 65535)
      $error("imwc_idle_wake: CpuStartCyc out of range");
    if (StabilizeCyc < 1 || StabilizeCyc > 65535)
      $error("imwc_idle_wake: StabilizeCyc out of range");
    if (OstCyc < 1 || OstCyc > 65535)
      $error("imwc_idle_wake: OstCyc out of range");
  end

  logic [31:0] oscCtrl_q;
  logic [31:0] wakeCtrl_q;
  logic primaryReady_q;
  logic secondaryRunning_q;
  logic intStable_q;
  logic irqWake_q;
  imwc_mode_t mode_q;
  imwc_src_t src_q;
  logic resetExit_q;
  logic [15:0] stabCnt_q;
  logic ackQ;
  logic [31:0] datQ;

  logic [1:0] clkSel;
  logic idleBit;
  logic intOutOn;
  logic wakeIrq;
  logic wakeEvent;
  logic busWrite;
  logic freqWrite;
  imwc_src_t selSrc;
  logic timerStart;
  logic [15:0] timerLoad;
  logic timerDone;
  logic timerBusy;

  assign clkSel = oscCtrl_q[CS_HI:CS_LO];
  assign idleBit = oscCtrl_q[IDLE_BIT];
  // A write lands at the edge where the master samples ack high
  assign busWrite = wb_cyc_i && wb_stb_i && wb_we_i && ackQ;

  // Frequency field changed by a write while internal source clocks the device
  assign freqWrite = busWrite && wb_adr_i == OFF_OSC_CTRL && wb_sel_i[0]
    && wb_dat_i[FREQ_LSB +: FREQ_W] != oscCtrl_q[FREQ_LSB +: FREQ_W]
    && src_q == SRC_INTERNAL;

  // Source requested by the select field; upper bit wins
  always_comb begin
    if (clkSel[1]) begin
      selSrc = SRC_INTERNAL;
    end else if (clkSel == CS_SECONDARY && oscCtrl_q[SEC_EN_BIT]) begin
      selSrc = SRC_SECONDARY;
    end else if (clkSel == CS_SECONDARY) begin
      selSrc = src_q; // Secondary not enabled: keep previous clock
    end else begin
      selSrc = SRC_PRIMARY;
    end
  end

  // Fast internal output enable
  assign intOutOn = oscCtrl_q[FREQ_LSB +: FREQ_W] != '0 ||
    oscCtrl_q[INT_SRC_BIT];

  // Interrupt qualifies only when enabled, peripheral needs PE
  assign wakeIrq = irqFlag && irqEnable &&
    (!irqIsPeripheral || wakeCtrl_q[PERIPHERAL_IRQ_ENABLE_BIT]);
  // Besides reset, only two triggers end a low-power mode
  assign wakeEvent = wakeIrq || watchdogTimeout;

  // Wishbone register writes; sleep never alters mode bits
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      oscCtrl_q <= OSC_CTRL_RST;
      wakeCtrl_q <= WAKE_CTRL_RST;
    end else if (busWrite) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b] && wb_adr_i == OFF_OSC_CTRL)
          oscCtrl_q[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
        if (wb_sel_i[b] && wb_adr_i == OFF_WAKE_CTRL)
          wakeCtrl_q[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
      end
    end
  end

  // Wishbone read mux and single-cycle ack; unmapped reads zero
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ackQ <= 1'b0;
      datQ <= 32'h0000_0000;
    end else begin
      ackQ <= wb_cyc_i && wb_stb_i && !ackQ;
      case (wb_adr_i)
        OFF_OSC_CTRL: datQ <= oscCtrl_q;
        OFF_OSC_STAT: datQ <= {29'h0, intStable_q, secondaryRunning_q,
                               primaryReady_q};
        OFF_WAKE_CTRL: datQ <= wakeCtrl_q;
        OFF_CPU_STAT: datQ <= {27'h0, resetExit_q, src_q, mode_q[1:0]};
        default: datQ <= 32'h0000_0000;
      endcase
    end
  end
  assign wb_ack_o = ackQ;
  assign wb_dat_o = datQ;

  // Power mode sequencer; reset exit is the sync reset itself
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      mode_q <= MODE_RUN;
      irqWake_q <= 1'b0;
    end else begin
      case (mode_q)
        MODE_RUN: begin
          if (sleepExec)
            mode_q <= idleBit ? MODE_IDLE : MODE_SLEEP;
        end
        MODE_SLEEP, MODE_IDLE: begin
          if (wakeEvent) begin
            mode_q <= MODE_WAKE;
            irqWake_q <= wakeIrq;
          end
        end
        MODE_WAKE: begin
          if (timerDone) mode_q <= MODE_RUN;
        end
        default: mode_q <= MODE_RUN;
      endcase
    end
  end

  // Active clock source: follows select in run and on entering idle
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      src_q <= SRC_PRIMARY;
    end else if (mode_q == MODE_RUN) begin
      src_q <= selSrc;
    end
  end

  // Primary ready and secondary running flags
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      primaryReady_q <= 1'b1;
      secondaryRunning_q <= 1'b0;
    end else if (mode_q == MODE_SLEEP) begin
      primaryReady_q <= 1'b0;
      secondaryRunning_q <= 1'b0;
    end else if (mode_q == MODE_WAKE && !timerDone) begin
      // Ready held through the wake delay: stays set out of primary idle,
      // stays clear out of sleep until the core runs on the clock
      secondaryRunning_q <= src_q == SRC_SECONDARY;
    end else begin
      primaryReady_q <= src_q == SRC_PRIMARY;
      secondaryRunning_q <= src_q == SRC_SECONDARY;
    end
  end

  // Internal stable flag after stabilization, kept if already stable
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      stabCnt_q <= '0;
      intStable_q <= 1'b0;
    end else if (!intOutOn || mode_q == MODE_SLEEP) begin
      stabCnt_q <= '0;
      intStable_q <= 1'b0;
    end else if (!intStable_q) begin
      if (stabCnt_q >= 16'(StabilizeCyc - 1))
        intStable_q <= 1'b1;
      else
        stabCnt_q <= stabCnt_q + 16'h0001;
    end
  end

  // Wake delay: start-up timer only for crystal primary out of sleep,
  // otherwise the fixed CPU start delay
  assign timerStart = (mode_q == MODE_SLEEP || mode_q == MODE_IDLE)
    && wakeEvent;
  assign timerLoad = (mode_q == MODE_SLEEP && src_q == SRC_PRIMARY &&
    oscCtrl_q[PRI_XTAL_BIT] && OstCyc > CpuStartCyc) ?
    16'(OstCyc) : 16'(CpuStartCyc);

  imwc_delay_timer #(
    .CntW(16)
  ) uDelay (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .start(timerStart),
    .loadVal(timerLoad),
    .busy(timerBusy),
    .done(timerDone)
  );

  // Restart-at-zero flag: set by device reset, cleared on first sleep
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      resetExit_q <= 1'b1;
    end else if (sleepExec) begin
      resetExit_q <= 1'b0;
    end
  end

  // Clock gating outputs
  assign cpuClockEn = mode_q == MODE_RUN;
  assign periphClockEn = mode_q != MODE_SLEEP;
  assign periphClockSrc = src_q;
  assign primaryOscEn = (src_q == SRC_PRIMARY) && mode_q != MODE_SLEEP;
  assign fastInternalOscEn = intOutOn && mode_q != MODE_SLEEP;
  assign slowInternalOscEn = wakeCtrl_q[WDT_EN_BIT] ||
    wakeCtrl_q[FSCM_EN_BIT] || src_q == SRC_INTERNAL;

  // Sequencing pulses and the restart-at-zero flag to the core
  assign cpuResume = mode_q == MODE_WAKE && timerDone;
  assign branchToVector = cpuResume && irqWake_q && wakeCtrl_q[GIE_BIT];
  assign watchdogReset = watchdogTimeout && mode_q == MODE_RUN;
  assign watchdogClear = (sleepExec && mode_q == MODE_RUN) ||
    watchdogClearInstr || (clockLoss && wakeCtrl_q[FSCM_EN_BIT]) ||
    freqWrite;
  assign restartAtZero = resetExit_q;

  // Assertions
  a_idle_cpu_off: assert property (@(posedge clk_sys) disable iff (!reset_n)
    mode_q == MODE_IDLE |-> !cpuClockEn && periphClockEn)
    else $error("idle mode left CPU clock on");
  a_sleep_all_off: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    mode_q == MODE_SLEEP |-> !cpuClockEn && !periphClockEn)
    else $error("sleep left a clock running");
  a_wake_delay: assert property (@(posedge clk_sys) disable iff (!reset_n)
    mode_q == MODE_IDLE && wakeEvent |-> ##1 !cpuClockEn [*2])
    else $error("CPU resumed without start delay");
  a_wake_bounded: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    mode_q == MODE_IDLE && wakeEvent |-> ##[1:70] cpuResume)
    else $error("CPU did not resume after idle wake");
  a_no_spur_wake: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    mode_q == MODE_IDLE && !wakeEvent |=> mode_q == MODE_IDLE)
    else $error("idle left without a trigger");
  a_wdt_reset: assert property (@(posedge clk_sys) disable iff (!reset_n)
    watchdogTimeout && mode_q != MODE_RUN |-> !watchdogReset)
    else $error("watchdog reset while not executing");
  a_wdt_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)
    watchdogClearInstr |-> watchdogClear)
    else $error("clear instruction did not clear watchdog");
  a_vector_gie: assert property (@(posedge clk_sys) disable iff (!reset_n)
    branchToVector |-> wakeCtrl_q[GIE_BIT] && irqWake_q)
    else $error("vector taken without global enable");
  a_mode_bits_kept: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    mode_q == MODE_WAKE && !busWrite |=> $stable(oscCtrl_q))
    else $error("wake altered mode bits");
  a_int_off_unstable: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    !intOutOn |=> !intStable_q)
    else $error("stable flag set with output off");
  a_ready_kept: assert property (@(posedge clk_sys) disable iff (!reset_n)
    mode_q == MODE_IDLE && src_q == SRC_PRIMARY |=> primaryReady_q)
    else $error("ready flag dropped in primary idle or its wake");

  c_idle_wake: cover property (@(posedge clk_sys) disable iff (!reset_n)
    mode_q == MODE_IDLE ##1 mode_q == MODE_WAKE);
  c_sleep_wake: cover property (@(posedge clk_sys) disable iff (!reset_n)
    mode_q == MODE_SLEEP ##1 mode_q == MODE_WAKE);
  c_vector: cover property (@(posedge clk_sys) disable iff (!reset_n)
    branchToVector);

endmodule

// >>> imwc_pkg.sv
// Package for the idle and wake controller: register map, field layout,
// reset values, power modes and timing counts.
// Assumes a 25 MHz system clock and a 32-bit classic Wishbone slave port.
package imwc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_OSC_CTRL = 8'h00;
  localparam logic [7:0] OFF_OSC_STAT = 8'h04;
  localparam logic [7:0] OFF_WAKE_CTRL = 8'h08;
  localparam logic [7:0] OFF_CPU_STAT = 8'h0c;

  // Oscillator control field positions
  localparam int CS_LO = 0;
  localparam int CS_HI = 1;
  localparam int IDLE_BIT = 2;
  localparam int SEC_EN_BIT = 3;
  localparam int INT_SRC_BIT = 4;
  localparam int FREQ_LSB = 5;
  localparam int FREQ_W = 3;
  localparam int PRI_XTAL_BIT = 8;

  // Wake control field positions
  localparam int GIE_BIT = 0;
  localparam int PERIPHERAL_IRQ_ENABLE_BIT = 1;
  localparam int WDT_EN_BIT = 2;
  localparam int FSCM_EN_BIT = 3;

  // Reset values
  localparam logic [31:0] OSC_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] WAKE_CTRL_RST = 32'h0000_0000;

  // Clock select encodings
  localparam logic [1:0] CS_PRIMARY = 2'h0;
  localparam logic [1:0] CS_SECONDARY = 2'h1;

  // Timing: system clock rate and derived cycle counts
  localparam int CLK_HZ = 25_000_000;
  localparam int CPU_START_NS = 1000;
  localparam int STABILIZE_NS = 4000;
  localparam int CPU_START_CYC =
    (CPU_START_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int STABILIZE_CYC =
    (STABILIZE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int OST_CYC = 1024;

  // Power modes
  typedef enum logic [2:0] {
    MODE_RUN,
    MODE_SLEEP,
    MODE_IDLE,
    MODE_WAKE
  } imwc_mode_t;

  // Clock source that feeds peripherals / CPU
  typedef enum logic [1:0] {
    SRC_PRIMARY,
    SRC_SECONDARY,
    SRC_INTERNAL,
    SRC_NONE
  } imwc_src_t;

endpackage

// >>> testbench.sv
// Self-checking bench for the idle and wake controller.
// Assumes the firmware model and the design files are compiled first.
`timescale 1ns/1ps
module testbench import imwc_pkg::*; ();
  localparam int StartC = 2;
  localparam int StabC = 3;
  localparam int OstC = 4;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck;
  logic [7:0] wbAdr = 8'h00;
  logic [31:0] wbDatW = 32'h0, wbDatR;
  logic sleepExec, watchdogClearInstr, irqFlag, irqEnable;
  logic irqIsPeripheral, watchdogTimeout, clockLoss;
  logic cpuClockEn, periphClockEn, primaryOscEn, fastInternalOscEn;
  logic slowInternalOscEn, cpuResume, branchToVector, watchdogReset;
  logic watchdogClear, restartAtZero;
  logic [1:0] periphClockSrc;
  logic [5:0] clkVec;
  logic [3:0] wbSel = 4'hf;
  logic [31:0] laneD;
  int failures = 0, samplesChecked = 0, n;

  assign clkVec = {cpuClockEn, periphClockEn, periphClockSrc, primaryOscEn,
                   fastInternalOscEn};

  // 25 MHz system clock
  always #20 clk_sys = ~clk_sys;

  imwc_idle_wake #(.CpuStartCyc(StartC), .StabilizeCyc(StabC),
                   .OstCyc(OstC)) imwc_idle_wake_i (
    .clk_sys(clk_sys), .reset_n(reset_n),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
    .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck),
    .sleepExec(sleepExec), .watchdogClearInstr(watchdogClearInstr),
    .irqFlag(irqFlag), .irqEnable(irqEnable),
    .irqIsPeripheral(irqIsPeripheral), .watchdogTimeout(watchdogTimeout),
    .clockLoss(clockLoss), .cpuClockEn(cpuClockEn),
    .periphClockEn(periphClockEn), .periphClockSrc(periphClockSrc),
    .primaryOscEn(primaryOscEn), .fastInternalOscEn(fastInternalOscEn),
    .slowInternalOscEn(slowInternalOscEn), .cpuResume(cpuResume),
    .branchToVector(branchToVector), .watchdogReset(watchdogReset),
    .watchdogClear(watchdogClear), .restartAtZero(restartAtZero));

  imwc_fw_model imwc_fw_model_i (
    .clk_sys(clk_sys), .cpuResume(cpuResume), .sleepExec(sleepExec),
    .watchdogClearInstr(watchdogClearInstr), .irqFlag(irqFlag),
    .irqEnable(irqEnable), .irqIsPeripheral(irqIsPeripheral),
    .watchdogTimeout(watchdogTimeout), .clockLoss(clockLoss));

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    samplesChecked++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Classic single cycle; the request stands until ack is sampled high
  task automatic wbXfer(input logic we, input logic [7:0] adr,
                        input logic [31:0] dw, input logic [3:0] sel,
                        output logic [31:0] dr);
    int k;
    k = 0;
    @(posedge clk_sys);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbSel <= sel;
    wbAdr <= adr;
    wbDatW <= dw;
    do begin
      @(posedge clk_sys);
      k++;
    end while (wbAck !== 1'b1 && k < 20);
    dr = wbDatR;
    check("wishbone ack", 1'b1, wbAck);
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dw);
    logic [31:0] d;
    wbXfer(1'b1, adr, dw, 4'hf, d);
  endtask

  task automatic rdChk(input logic [7:0] adr, input logic [31:0] exp,
                       input string what);
    logic [31:0] d;
    wbXfer(1'b0, adr, 32'h0, 4'hf, d);
    check(what, exp, d);
  endtask

  // Reset held for 16 cycles; also used to leave a low-power mode
  task automatic resetDut();
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(negedge clk_sys);
  endtask

  // Sleep strobe, then the clock vector once the mode has moved
  task automatic sleepChk(input logic [5:0] exp, input logic [5:0] mask);
    imwc_fw_model_i.strobe(0);
    @(negedge clk_sys);
    check("sleep clears watchdog", 1'b1, watchdogClear);
    @(negedge clk_sys);
    check("idle clocks", exp, clkVec & mask);
  endtask

  // Counts cycles from the wake event to the resume pulse
  task automatic waitResume(output int k);
    k = 0;
    @(negedge clk_sys);
    while (cpuResume !== 1'b1 && k < 200) begin
      @(negedge clk_sys);
      k++;
    end
    check("resume seen", 1'b1, cpuResume);
  endtask

  task automatic conclude();
    $display("Checks %0d mismatches %0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Hang guard, well beyond the few hundred cycles the tests need
  initial begin
    #200000;
    failures++;
    $display("Error run time expected end seen hang");
    conclude();
  end

  initial begin
    resetDut();
    check("run clocks", 6'h32, clkVec);
    rdChk(OFF_OSC_CTRL, OSC_CTRL_RST, "osc ctrl reset");
    rdChk(OFF_WAKE_CTRL, WAKE_CTRL_RST, "wake ctrl reset");
    rdChk(OFF_OSC_STAT, 32'h1, "osc stat reset");
    rdChk(OFF_CPU_STAT, 32'h10, "cpu stat reset");
    wr(8'h10, 32'hffff_ffff);
    rdChk(8'h10, 32'h0, "unmapped read");
    // Only the selected byte lane may land
    wbXfer(1'b1, OFF_WAKE_CTRL, 32'h0000_ff0f, 4'h2, laneD);
    rdChk(OFF_WAKE_CTRL, 32'h0000_ff00, "lane write");
    wr(OFF_WAKE_CTRL, 32'h0);
    $display("Test reset state done");
    // Primary idle with a crystal: no start-up timer on this exit
    wr(OFF_OSC_CTRL, 32'h104);
    sleepChk(6'h12, 6'h3f);
    rdChk(OFF_OSC_STAT, 32'h1, "ready in idle");
    imwc_fw_model_i.irq(1'b1, 1'b0);
    waitResume(n);
    check("primary wake delay", StartC + 1, n);
    check("no vector", 1'b0, branchToVector);
    @(negedge clk_sys);
    check("primary run", 6'h32, clkVec);
    rdChk(OFF_OSC_CTRL, 32'h104, "bits kept");
    $display("Test primary idle done");
    // Secondary idle, left by a watchdog time-out
    wr(OFF_OSC_CTRL, 32'hd);
    sleepChk(6'h14, 6'h3f);
    rdChk(OFF_OSC_STAT, 32'h2, "secondary flags");
    imwc_fw_model_i.strobe(2);
    waitResume(n);
    check("watchdog wake delay", StartC + 1, n);
    @(negedge clk_sys);
    check("secondary run", 6'h34, clkVec);
    rdChk(OFF_OSC_CTRL, 32'hd, "bits kept");
    sleepChk(6'h14, 6'h3f);
    resetDut();
    check("reset exit", 1'b1, restartAtZero);
    check("reset clocks", 6'h32, clkVec);
    $display("Test secondary idle done");
    // Secondary chosen with its oscillator off stays on primary
    wr(OFF_OSC_CTRL, 32'h5);
    sleepChk(6'h12, 6'h3f);
    imwc_fw_model_i.irq(1'b1, 1'b0);
    waitResume(n);
    check("fallback wake delay", StartC + 1, n);
    $display("Test fallback idle done");
    // Internal idle; peripheral interrupt refused until its enable is set
    wr(OFF_WAKE_CTRL, 32'h1);
    wr(OFF_OSC_CTRL, 32'h66);
    sleepChk(6'h19, 6'h3f);
    repeat (StabC + 4) @(posedge clk_sys);
    rdChk(OFF_OSC_STAT, 32'h4, "internal stable");
    imwc_fw_model_i.irq(1'b1, 1'b1);
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    check("no wake yet", 1'b0, cpuClockEn);
    wr(OFF_WAKE_CTRL, 32'h7);
    check("slow osc kept", 1'b1, slowInternalOscEn);
    waitResume(n);
    check("vector taken", 1'b1, branchToVector);
    @(negedge clk_sys);
    check("internal run", 6'h39, clkVec);
    rdChk(OFF_OSC_STAT, 32'h4, "stable kept");
    $display("Test internal idle done");
    // Watchdog events while running
    imwc_fw_model_i.strobe(2);
    @(negedge clk_sys);
    check("run time-out resets", 1'b1, watchdogReset);
    imwc_fw_model_i.strobe(1);
    @(negedge clk_sys);
    check("clear instr", 1'b1, watchdogClear);
    wr(OFF_WAKE_CTRL, 32'h8);
    imwc_fw_model_i.strobe(3);
    @(negedge clk_sys);
    check("clock loss clears", 1'b1, watchdogClear);
    $display("Test watchdog done");
    // Full sleep with a crystal primary pays the start-up timer
    resetDut();
    check("slow osc off", 1'b0, slowInternalOscEn);
    wr(OFF_WAKE_CTRL, 32'h4);
    check("slow osc for watchdog", 1'b1, slowInternalOscEn);
    wr(OFF_OSC_CTRL, 32'h100);
    sleepChk(6'h00, 6'h30);
    imwc_fw_model_i.irq(1'b1, 1'b0);
    waitResume(n);
    check("crystal wake delay", OstC + 1, n);
    $display("Test sleep done");
    conclude();
  end
endmodule
